// ### wuelfc_regs.vh
`ifndef WUELFC_REGS_VH
`define WUELFC_REGS_VH

////////////////////////////////////////////////////////////////////////////
// Address decode
`define WUELFC_BASE_BLOCKING    4'h2
`define WUELFC_BASE_NONBLOCKING 4'h3
`define WUELFC_OFF_STATUS_HI    8'h02
`define WUELFC_OFF_STATUS_LO    8'h03
`define WUELFC_OFF_DIV_HI       8'h04
`define WUELFC_OFF_DIV_LO       8'h05
`define WUELFC_OFF_WUE_HI       8'h06
`define WUELFC_OFF_WUE_LO       8'h07
`define WUELFC_OFF_TRIM_HI      8'h0E
`define WUELFC_OFF_TRIM_LO      8'h0F

////////////////////////////////////////////////////////////////////////////
// Field positions
`define WUELFC_WUE_CHARGE_BIT   7
`define WUELFC_WUE_CURRENT_BIT  6
`define WUELFC_WUE_CAL_BIT      5
`define WUELFC_WUE_BUS_BIT      4
`define WUELFC_WUE_LTC_BIT      7
`define WUELFC_ST_LTC_BIT       1
`define WUELFC_ST_LPM_BIT       0
`define WUELFC_TRIM_READY_BIT   15
`define WUELFC_EVENT_LTC        8

////////////////////////////////////////////////////////////////////////////
// Reset values
`define WUELFC_WUE_RESET        8'h00
`define WUELFC_DIV_RESET        16'h1000
`define WUELFC_ACTIVE_RESET     13'h0200
`define WUELFC_FAST_SHIFT       3

`endif

// ### wuelfc_ms_divider.v
`timescale 1ns/100ps
// Divides the link clock by the millisecond value into two tick trains
module wuelfc_ms_divider (
  core_clk,
  rst,
  divValue,
  restart,
  slowTick_q,
  fastTick_q
);
`include "wuelfc_regs.vh"
  input  wire        core_clk;    // Link clock
  input  wire        rst;         // Synchronous reset
  input  wire [15:0] divValue;    // Millisecond divider value
  input  wire        restart;     // Restart both counters
  output reg         slowTick_q;  // One pulse per divider period
  output reg         fastTick_q;  // Pulse every eighth of a period

  reg  [15:0] slowCnt_q;          // Slow period counter
  reg  [15:0] fastCnt_q;          // Fast period counter
  wire [15:0] fastValue;          // Fast period length
  wire [15:0] slowLast;           // Last count of slow period
  wire [15:0] fastLast;           // Last count of fast period

  assign fastValue = divValue >> `WUELFC_FAST_SHIFT;
  // Zero lengths behave as one cycle so ticks never stop
  assign slowLast = (divValue == 16'h0000) ? 16'h0000 : divValue - 16'h0001;
  assign fastLast = (fastValue == 16'h0000) ? 16'h0000 : fastValue - 16'h0001;

  //////////////////////////////////////////////////////////////////////////
  // Slow and fast counters
  always @(posedge core_clk) begin
    if (rst || restart) begin
      slowCnt_q  <= 16'h0000;
      fastCnt_q  <= 16'h0000;
      slowTick_q <= 1'b0;
      fastTick_q <= 1'b0;
    end else begin
      // Slow train: one tick each divider period
      if (slowCnt_q >= slowLast) begin
        slowCnt_q  <= 16'h0000;
        slowTick_q <= 1'b1;
      end else begin
        slowCnt_q  <= slowCnt_q + 16'h0001;
        slowTick_q <= 1'b0;
      end
      // Fast train: eight ticks per divider period
      if (fastCnt_q >= fastLast) begin
        fastCnt_q  <= 16'h0000;
        fastTick_q <= 1'b1;
      end else begin
        fastCnt_q  <= fastCnt_q + 16'h0001;
        fastTick_q <= 1'b0;
      end
    end
  end
endmodule

// ### wuelfc_cal_clock.v
`timescale 1ns/100ps
// Measures the low-power oscillator against the millisecond tick
module wuelfc_cal_clock (
  core_clk,
  rst,
  slowTick,
  oscTick,
  resync,
  fineField,
  lowPowerMode,
  ready_q,
  active_q,
  lifetimeTick_q,
  timerTick_q,
  currentTick_q
);
`include "wuelfc_regs.vh"
  input  wire        core_clk;        // Link clock
  input  wire        rst;             // Synchronous reset
  input  wire        slowTick;        // Millisecond tick
  input  wire        oscTick;         // Low-power oscillator tick
  input  wire        resync;          // Start a new synchronisation
  input  wire [1:0]  fineField;       // Fine correction
  input  wire        lowPowerMode;    // Device in low-power mode
  output reg         ready_q;         // Synchronisation complete
  output reg  [12:0] active_q;        // Active divider value
  output reg         lifetimeTick_q;  // Calibrated tick, all modes
  output reg         timerTick_q;     // Calibrated tick, low power only
  output reg         currentTick_q;   // Calibrated tick, low power only

  localparam S_WAIT = 3'b001;         // Waiting for period start
  localparam S_MEAS = 3'b010;         // Counting oscillator ticks
  localparam S_DONE = 3'b100;         // Synchronised

  reg  [2:0]  state_q;                // Sync state
  reg  [12:0] measCnt_q;              // Oscillator ticks in period
  reg  [12:0] calCnt_q;               // Calibrated clock counter
  wire [13:0] measSum;                // Count plus fine correction
  wire [12:0] measNext;               // Saturated count
  wire [12:0] calLast;                // Last count of calibrated period

  assign measSum  = {1'b0, measCnt_q} + {12'h000, fineField};
  assign measNext = measSum[13] ? 13'h1FFF : measSum[12:0];
  assign calLast  = (active_q == 13'h0000) ? 13'h0000 : active_q - 13'h0001;

  //////////////////////////////////////////////////////////////////////////
  // Synchronisation sequencer
  always @(posedge core_clk) begin
    if (rst) begin
      state_q   <= S_WAIT;
      ready_q   <= 1'b0;
      active_q  <= `WUELFC_ACTIVE_RESET;
      measCnt_q <= 13'h0000;
    end else if (resync) begin
      // A divider or fine change drops the ready flag
      state_q   <= S_WAIT;
      ready_q   <= 1'b0;
      measCnt_q <= 13'h0000;
    end else begin
      case (state_q)
        S_WAIT: begin
          if (slowTick) begin
            state_q   <= S_MEAS;
            // Opening edge counts, closing edge does not: no lost tick
            measCnt_q <= {12'h000, oscTick};
          end
        end
        S_MEAS: begin
          if (slowTick) begin
            // Period closed: load measured divider
            active_q <= measNext;
            ready_q  <= 1'b1;
            state_q  <= S_DONE;
          end else if (oscTick && measCnt_q != 13'h1FFF) begin
            measCnt_q <= measCnt_q + 13'h0001;
          end
        end
        S_DONE: begin
          state_q <= S_DONE;
        end
        default: begin
          state_q <= S_WAIT;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Calibrated clock from the oscillator and the active divider
  always @(posedge core_clk) begin
    if (rst) begin
      calCnt_q       <= 13'h0000;
      lifetimeTick_q <= 1'b0;
      timerTick_q    <= 1'b0;
      currentTick_q  <= 1'b0;
    end else begin
      lifetimeTick_q <= 1'b0;
      timerTick_q    <= 1'b0;
      currentTick_q  <= 1'b0;
      if (oscTick) begin
        if (calCnt_q >= calLast) begin
          calCnt_q       <= 13'h0000;
          lifetimeTick_q <= 1'b1;
          timerTick_q    <= lowPowerMode;
          currentTick_q  <= lowPowerMode;
        end else begin
          calCnt_q <= calCnt_q + 13'h0001;
        end
      end
    end
  end
endmodule

// ### wuelfc_top.v
`timescale 1ns/100ps
// Wake-up enables, wake causes and low-frequency clock control
module wuelfc_top (
  core_clk,
  rst,
  regAddr,
  regWrEn,
  regRdEn,
  regWide,
  regWrData,
  regRdData_q,
  regRdValid_q,
  lowPowerMode,
  wakeEvents,
  oscTick,
  dividerFineField,
  wakeRequest_q,
  dieLinkSlowClock_q,
  dieLinkFastClock_q,
  dividerReadyFlag_q,
  activeDividerValue_q,
  lifetimeTick_q,
  timerTick_q,
  currentTick_q
);
`include "wuelfc_regs.vh"
  input  wire        core_clk;              // Die link clock
  input  wire        rst;                   // Power-up reset
  input  wire [11:0] regAddr;               // Global register address
  input  wire        regWrEn;               // Write strobe
  input  wire        regRdEn;               // Read strobe
  input  wire        regWide;               // 16-bit transfer
  input  wire [15:0] regWrData;             // Write data
  output reg  [15:0] regRdData_q;           // Read data
  output reg         regRdValid_q;          // Read data valid
  input  wire        lowPowerMode;          // Device in low-power mode
  input  wire [8:0]  wakeEvents;            // Wake source pulses
  input  wire        oscTick;               // Low-power oscillator tick
  input  wire [1:0]  dividerFineField;      // Fine correction
  output reg         wakeRequest_q;         // Leave low-power mode
  output wire        dieLinkSlowClock_q;    // Slow link tick
  output wire        dieLinkFastClock_q;    // Fast link tick
  output wire        dividerReadyFlag_q;    // Calibrated clock synced
  output wire [12:0] activeDividerValue_q;  // Active divider
  output wire        lifetimeTick_q;        // Lifetime counter tick
  output wire        timerTick_q;           // Timer tick
  output wire        currentTick_q;         // Current trigger tick

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0]  wakeEnableHigh_q;             // Pin, bus and sensor enables
  reg         wakeLifetimeOverflowEn_q;     // Lifetime overflow enable
  reg  [15:0] msDividerValue_q;             // Millisecond divider
  reg  [7:0]  wakeCause_q;                  // Wake causes, low byte
  reg         wakeLtcCause_q;               // Lifetime wake cause
  reg         wakeLpmCause_q;               // Wake after low power
  reg  [1:0]  fine_q;                       // Last fine field seen
  reg         resync_q;                     // Restart synchronisation
  reg         divRestart_q;                 // Restart divider counters

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire        baseHit;                      // Block address space
  wire [7:0]  off;                          // Offset in block
  wire [7:0]  offPair;                      // Even offset of wide access
  wire        wr;                           // Block write
  wire [8:0]  enables;                      // All nine enables
  wire [8:0]  wakeHits;                     // Enabled events in low power
  wire [15:0] trimWord;                     // Trim pair
  wire [15:0] statusWord;                   // Status pair
  wire [15:0] wueWord;                      // Enable pair
  wire        wrWueHi;                      // Write enable high byte
  wire        wrWueLo;                      // Write enable low byte
  wire        wrStHi;                       // Write status high byte
  wire        wrStLo;                       // Write status low byte
  wire        wrDiv;                        // Wide divider write
  wire [7:0]  dHi;                          // Byte for even offset
  wire [7:0]  dLo;                          // Byte for odd offset

  // Both base windows map to the same registers
  assign baseHit = (regAddr[11:8] == `WUELFC_BASE_BLOCKING) ||
                   (regAddr[11:8] == `WUELFC_BASE_NONBLOCKING);
  assign off     = regAddr[7:0];
  assign offPair = {regAddr[7:1], 1'b0};
  assign wr      = regWrEn && baseHit;
  assign dHi     = regWide ? regWrData[15:8] : regWrData[7:0];
  assign dLo     = regWrData[7:0];

  // Wide accesses cover the even byte and the following odd byte
  assign wrWueHi = wr && (regWide ? offPair == `WUELFC_OFF_WUE_HI
                                  : off == `WUELFC_OFF_WUE_HI);
  assign wrWueLo = wr && (regWide ? offPair == `WUELFC_OFF_WUE_HI
                                  : off == `WUELFC_OFF_WUE_LO);
  assign wrStHi  = wr && (regWide ? offPair == `WUELFC_OFF_STATUS_HI
                                  : off == `WUELFC_OFF_STATUS_HI);
  assign wrStLo  = wr && (regWide ? offPair == `WUELFC_OFF_STATUS_HI
                                  : off == `WUELFC_OFF_STATUS_LO);
  // Byte writes to the divider are dropped
  assign wrDiv   = wr && regWide && (offPair == `WUELFC_OFF_DIV_HI);

  assign enables  = {wakeLifetimeOverflowEn_q, wakeEnableHigh_q};
  // Disabled sources cannot end low power
  assign wakeHits = lowPowerMode ? (wakeEvents & enables) : 9'h000;

  // Bits 14 and 13 of trim read zero
  assign trimWord   = {dividerReadyFlag_q, 2'b00,
                       activeDividerValue_q};
  assign statusWord = {6'h00, wakeLtcCause_q, wakeLpmCause_q,
                       wakeCause_q};
  assign wueWord    = {wakeEnableHigh_q, wakeLifetimeOverflowEn_q,
                       7'h00};

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always @(posedge core_clk) begin
    if (rst) begin
      wakeEnableHigh_q         <= `WUELFC_WUE_RESET;
      wakeLifetimeOverflowEn_q <= 1'b0;
      msDividerValue_q         <= `WUELFC_DIV_RESET;
      divRestart_q             <= 1'b0;
    end else begin
      divRestart_q <= wrDiv;
      if (wrWueHi) begin
        // Charge, current, calibration, bus and four pin enables
        wakeEnableHigh_q <= dHi;
      end
      if (wrWueLo) begin
        wakeLifetimeOverflowEn_q <= dLo[`WUELFC_WUE_LTC_BIT];
      end
      if (wrDiv) begin
        msDividerValue_q <= regWrData;
      end
      // Trim writes have no branch here at all
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake causes and wake request; a new cause beats a clear
  always @(posedge core_clk) begin
    if (rst) begin
      wakeCause_q    <= 8'h00;
      wakeLtcCause_q <= 1'b0;
      wakeLpmCause_q <= 1'b0;
      wakeRequest_q  <= 1'b0;
    end else begin
      wakeRequest_q  <= |wakeHits;
      wakeCause_q    <= (wakeCause_q & ~(wrStLo ? dLo : 8'h00)) |
                        wakeHits[7:0];
      wakeLtcCause_q <= (wakeLtcCause_q &
                        ~(wrStHi && dHi[`WUELFC_ST_LTC_BIT])) |
                        wakeHits[`WUELFC_EVENT_LTC];
      wakeLpmCause_q <= (wakeLpmCause_q &
                        ~(wrStHi && dHi[`WUELFC_ST_LPM_BIT])) |
                        (|wakeHits);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resynchronise on divider or fine field change
  always @(posedge core_clk) begin
    if (rst) begin
      fine_q   <= 2'b00;
      resync_q <= 1'b0;
    end else begin
      fine_q   <= dividerFineField;
      resync_q <= (wrDiv && regWrData != msDividerValue_q) ||
                  (fine_q != dividerFineField);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, one cycle after the strobe
  always @(posedge core_clk) begin
    if (rst) begin
      regRdData_q  <= 16'h0000;
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regRdEn;
      regRdData_q  <= 16'h0000;
      if (regRdEn && baseHit) begin
        if (regWide) begin
          case (offPair)
            `WUELFC_OFF_STATUS_HI: regRdData_q <= statusWord;
            `WUELFC_OFF_DIV_HI:    regRdData_q <= msDividerValue_q;
            `WUELFC_OFF_WUE_HI:    regRdData_q <= wueWord;
            `WUELFC_OFF_TRIM_HI:   regRdData_q <= trimWord;
            default:               regRdData_q <= 16'h0000;
          endcase
        end else begin
          // Byte reads; the divider answers zero
          case (off)
            `WUELFC_OFF_STATUS_HI: regRdData_q <= {8'h00, statusWord[15:8]};
            `WUELFC_OFF_STATUS_LO: regRdData_q <= {8'h00, statusWord[7:0]};
            `WUELFC_OFF_WUE_HI:    regRdData_q <= {8'h00, wueWord[15:8]};
            `WUELFC_OFF_WUE_LO:    regRdData_q <= {8'h00, wueWord[7:0]};
            `WUELFC_OFF_TRIM_HI:   regRdData_q <= {8'h00, trimWord[15:8]};
            `WUELFC_OFF_TRIM_LO:   regRdData_q <= {8'h00, trimWord[7:0]};
            default:               regRdData_q <= 16'h0000;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond divider
  wuelfc_ms_divider u_div (
    .core_clk   (core_clk),
    .rst        (rst),
    .divValue   (msDividerValue_q),
    .restart    (divRestart_q),
    .slowTick_q (dieLinkSlowClock_q),
    .fastTick_q (dieLinkFastClock_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Calibrated low-frequency clock
  wuelfc_cal_clock u_cal (
    .core_clk       (core_clk),
    .rst            (rst),
    .slowTick       (dieLinkSlowClock_q),
    .oscTick        (oscTick),
    .resync         (resync_q),
    .fineField      (dividerFineField),
    .lowPowerMode   (lowPowerMode),
    .ready_q        (dividerReadyFlag_q),
    .active_q       (activeDividerValue_q),
    .lifetimeTick_q (lifetimeTick_q),
    .timerTick_q    (timerTick_q),
    .currentTick_q  (currentTick_q)
  );
endmodule

// ### wuelfc_dummy_unused.v
`timescale 1ns/100ps

// ### wuelfc_chk_assertions.sv
`timescale 1ns/100ps
// Port checker for the wake-up enable and slow clock block
module wuelfc_chk (
  input logic        core_clk,
  input logic        rst,
  input logic [11:0] regAddr,
  input logic        regWrEn,
  input logic        regRdEn,
  input logic        regWide,
  input logic [15:0] regWrData,
  input logic [15:0] regRdData_q,
  input logic        regRdValid_q,
  input logic        lowPowerMode,
  input logic [8:0]  wakeEvents,
  input logic        oscTick,
  input logic [1:0]  dividerFineField,
  input logic        wakeRequest_q,
  input logic        dieLinkSlowClock_q,
  input logic        dieLinkFastClock_q,
  input logic        dividerReadyFlag_q,
  input logic [12:0] activeDividerValue_q,
  input logic        lifetimeTick_q,
  input logic        timerTick_q,
  input logic        currentTick_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Wide write to the divider pair on either base
  wire divWr = regWrEn && regWide && regAddr[7:1] == 7'h02 &&
               regAddr[11:9] == 3'b001;
`include "wuelfc_regs.vh"
  // Last divider value written; only a new value forces a resync
  logic [15:0] divShadow;
  always @(posedge core_clk) begin
    if (rst)
      divShadow <= `WUELFC_DIV_RESET;
    else if (divWr)
      divShadow <= regWrData;
  end
  chk_rd_answer: assert property (regRdEn |=> regRdValid_q)
    else $error("read strobe not answered");
  chk_rd_single: assert property (!regRdEn |=> !regRdValid_q)
    else $error("read valid without strobe");
  chk_rd_idle: assert property (!regRdValid_q |-> !(|regRdData_q))
    else $error("read data not cleared");
  chk_wake_cause: assert property (wakeRequest_q |->
    $past(lowPowerMode) && $past(|wakeEvents))
    else $error("wake request without event in low power");
  chk_active_start: assert property ($fell(rst) |->
    activeDividerValue_q == 13'h0200 && !dividerReadyFlag_q)
    else $error("active divider not at start value");
  chk_ready_drop: assert property ((divWr && regWrData != divShadow) |->
    ##2 !dividerReadyFlag_q)
    else $error("ready kept after divider change");
  chk_active_sync: assert property (!$stable(activeDividerValue_q) |->
    ##[0:1] dividerReadyFlag_q)
    else $error("active divider moved without sync");
  chk_timer_lpm: assert property (timerTick_q |->
    $past(lowPowerMode) || $past(lowPowerMode, 2))
    else $error("timer tick outside low power");
  chk_current_lpm: assert property (currentTick_q |->
    $past(lowPowerMode) || $past(lowPowerMode, 2))
    else $error("current tick outside low power");
  chk_slow_gap: assert property ((dieLinkSlowClock_q &&
    divShadow > 16'h0008) |->
    ##1 !dieLinkSlowClock_q [*8])
    else $error("slow tick too soon");
  // Main scenarios reached
  cover property (wakeRequest_q);
  cover property ($rose(dividerReadyFlag_q));
  cover property (timerTick_q);
endmodule

// ### wuelfc_mcu_model.sv
`timescale 1ns/100ps
// Controller side: one register access at a time, off the falling edge
module wuelfc_mcu_model (
  input  logic        core_clk,
  input  logic [15:0] regRdData_q,
  input  logic        regRdValid_q,
  output logic [11:0] regAddr,
  output logic        regWrEn,
  output logic        regRdEn,
  output logic        regWide,
  output logic [15:0] regWrData
);
  // Idle bus at time zero
  initial begin
    regAddr   = 12'h000;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regWide   = 1'b1;
    regWrData = 16'h0000;
  end
  // One-cycle write strobe, data inverted once released
  task automatic wr(input logic [11:0] a, input logic w,
                    input logic [15:0] d);
    @(negedge core_clk);
    regAddr   = a;
    regWide   = w;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge core_clk);
    regWrEn   = 1'b0;
    regWrData = ~d;
  endtask
  // One-cycle read strobe, data taken with the valid pulse
  task automatic rd(input logic [11:0] a, input logic w,
                    output logic [15:0] d);
    int i;
    @(negedge core_clk);
    regAddr = a;
    regWide = w;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    d = 16'hXXXX;
    // Valid stands one cycle after the taking edge; look mid-cycle
    for (i = 0; i < 4; i++) begin
      if (regRdValid_q === 1'b1) begin
        d = regRdData_q;
        break;
      end
      @(negedge core_clk);
    end
  endtask
endmodule

// ### test_wakeup_enable_and_lowfreq_clock.sv
`timescale 1ns/100ps
// Register, wake and slow clock tests
module test_wakeup_enable_and_lowfreq_clock;
  logic        core_clk, rst, regWrEn, regRdEn, regWide, lowPowerMode;
  logic        oscTick, wakeRequest_q, regRdValid_q;
  logic [11:0] regAddr;
  logic [15:0] regWrData, regRdData_q, d, en, cause;
  logic [8:0]  wakeEvents;
  logic [1:0]  dividerFineField;
  logic [2:0]  oscCnt;
  logic [12:0] activeDividerValue_q;
  wire  [3:0]  ticks;
  int          errCount, nChecks, i;
  wuelfc_top DUT (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWide(regWide),
    .regWrData(regWrData), .regRdData_q(regRdData_q),
    .regRdValid_q(regRdValid_q), .lowPowerMode(lowPowerMode),
    .wakeEvents(wakeEvents), .oscTick(oscTick),
    .dividerFineField(dividerFineField), .wakeRequest_q(wakeRequest_q),
    .dieLinkSlowClock_q(ticks[0]), .dieLinkFastClock_q(ticks[1]),
    .dividerReadyFlag_q(ticks[3]),
    .activeDividerValue_q(activeDividerValue_q),
    .lifetimeTick_q(ticks[2]), .timerTick_q(), .currentTick_q());
  wuelfc_mcu_model mcu (.core_clk(core_clk), .regRdData_q(regRdData_q),
    .regRdValid_q(regRdValid_q), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWide(regWide), .regWrData(regWrData));
  // Clock and oscillator tick every eighth cycle
  always #4 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    oscCnt  <= oscCnt + 3'd1;
    oscTick <= (oscCnt == 3'd7);
  end
  // Compare and count
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] v;
    mcu.rd(a, 1'b1, v);
    chk16(v, exp);
  endtask
  // Cycles between two pulses of one tick line
  task automatic gap(input int s, output logic [15:0] n);
    int k;
    // Both pulses are seen just after the edge that launches them
    for (k = 0; k < 3000; k++) begin
      @(posedge core_clk);
      #1;
      if (ticks[s] === 1'b1) break;
    end
    for (k = 1; k < 3000; k++) begin
      @(posedge core_clk);
      #1;
      if (ticks[s] === 1'b1) break;
    end
    n = k[15:0];
  endtask
  task automatic wait_ready;
    int k;
    for (k = 0; k < 20000 && ticks[3] !== 1'b1; k++) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // One event pulse, count wake requests that follow
  task automatic wake(input int s, input logic lp, input logic [15:0] exp);
    int k;
    logic [15:0] n;
    @(negedge core_clk);
    lowPowerMode = lp;
    wakeEvents   = 9'h001 << s;
    @(negedge core_clk);
    wakeEvents   = 9'h000;
    n = 16'h0000;
    // The request stands one cycle, so look mid-cycle
    for (k = 0; k < 3; k++) begin
      if (wakeRequest_q === 1'b1) n++;
      @(negedge core_clk);
    end
    chk16(n, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    oscCnt = 3'd0;
    oscTick = 1'b0;
    lowPowerMode = 1'b0;
    wakeEvents = 9'h000;
    dividerFineField = 2'b00;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    rdchk(12'h206, 16'h0000);
    rdchk(12'h20E, 16'h0200);
    wait_ready;
    rdchk(12'h20E, 16'h8200);
    mcu.wr(12'h306, 1'b1, 16'hFFFF);
    rdchk(12'h206, 16'hFF80);
    mcu.wr(12'h20E, 1'b1, 16'h1234);
    rdchk(12'h30E, 16'h8200);
    rdchk(12'h106, 16'h0000);
    for (i = 0; i < 9; i++) begin
      en = (i == 8) ? 16'h0080 : (16'h0100 << i);
      cause = (i == 8) ? 16'h0200 : (16'h0001 << i);
      mcu.wr(12'h206, 1'b1, ~en & 16'hFF80);
      wake(i, 1'b1, 16'h0000);
      mcu.wr(12'h206, 1'b1, en);
      wake(i, 1'b0, 16'h0000);
      wake(i, 1'b1, 16'h0001);
      mcu.rd(12'h202, 1'b1, d);
      chk16(d, cause | 16'h0100);
      mcu.wr(12'h202, 1'b1, 16'hFFFF);
      rdchk(12'h202, 16'h0000);
    end
    mcu.wr(12'h204, 1'b0, 16'h00AA);
    rdchk(12'h204, 16'h1000);
    mcu.wr(12'h204, 1'b1, 16'h0100);
    rdchk(12'h304, 16'h0100);
    gap(0, d);
    chk16(d, 16'h0100);
    gap(1, d);
    chk16(d, 16'h0020);
    wait_ready;
    rdchk(12'h20E, 16'h8020);
    gap(2, d);
    chk16(d, 16'h0100);
    @(negedge core_clk);
    dividerFineField = 2'b01;
    repeat (4) @(negedge core_clk);
    wait_ready;
    rdchk(12'h20E, 16'h8021);
    chk16({3'h0, activeDividerValue_q}, 16'h0021);
    print_verdict;
  end
  // Watchdog well beyond the expected run
  initial begin
    #(60000 * 8);
    errCount++;
    print_verdict;
  end
endmodule
bind wuelfc_top wuelfc_chk u_chk (.core_clk(core_clk), .rst(rst),
  .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regWide(regWide), .regWrData(regWrData), .regRdData_q(regRdData_q),
  .regRdValid_q(regRdValid_q), .lowPowerMode(lowPowerMode),
  .wakeEvents(wakeEvents), .oscTick(oscTick),
  .dividerFineField(dividerFineField), .wakeRequest_q(wakeRequest_q),
  .dieLinkSlowClock_q(dieLinkSlowClock_q),
  .dieLinkFastClock_q(dieLinkFastClock_q),
  .dividerReadyFlag_q(dividerReadyFlag_q),
  .activeDividerValue_q(activeDividerValue_q),
  .lifetimeTick_q(lifetimeTick_q), .timerTick_q(timerTick_q),
  .currentTick_q(currentTick_q));
